// ==== hw/fdza_store.sv ====
// factory default restore and zero adjust configuration store
// =========================================================================
// =========================================================================
`timescale 1ns/1ps
`default_nettype none

module fdza_store
    import fdza_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire fdza_od_req_t       od_req,
    output logic                    od_ack,
    output logic                    od_abort,
    output logic [31:0]             od_rdata,
    input  wire logic signed [15:0] x_raw_incl,
    input  wire logic signed [15:0] y_raw_incl,
    input  wire logic [15:0]        x_cal_offset,
    input  wire logic [15:0]        y_cal_offset,
    input  wire logic               two_axis_pin,
    output logic signed [15:0]      x_incl_out,
    output logic signed [15:0]      y_incl_out,
    output fdza_cfg_t               cfg_out,
    output logic                    nv_commit,
    output fdza_nv_t                nv_scope
);

    // =====================================================================
    // reset release and pin synchroniser
    logic       rst_s1_q;
    logic       rst_s2_q;
    logic [1:0] axis_sync_q;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            axis_sync_q <= 2'b00;
        end
        else
        begin
            axis_sync_q <= {axis_sync_q[0], two_axis_pin};
        end
    end

    // =====================================================================
    // state
    typedef struct packed {
        fdza_cfg_t          cfg;
        logic               cal_loaded;
        logic               two_axis;
        logic [7:0]         zero_status;
        fdza_od_rsp_t       rsp;
        logic signed [15:0] x_out;
        logic signed [15:0] y_out;
        logic               nv_commit;
        fdza_nv_t           nv_scope;
    } fdza_state_t;

    fdza_state_t st_q;
    fdza_state_t st_d;

    // wraps a difference back into the half-turn range
    function automatic logic signed [17:0] fdza_wrap(input logic signed [17:0] v);
        logic signed [17:0] r;
        r = v;
        if (r > FDZA_HALF_TURN)
        begin
            r = r - FDZA_FULL_TURN;
        end
        else if (r < -FDZA_HALF_TURN)
        begin
            r = r + FDZA_FULL_TURN;
        end
        return r;
    endfunction

    // offset that makes the current reading show the preset value
    function automatic logic signed [17:0] fdza_offset_for(
        input logic signed [15:0] raw,
        input logic signed [15:0] target
    );
        return fdza_wrap(18'(raw) - 18'(target));
    endfunction

    // a two-axis part only takes offsets near horizontal
    function automatic logic fdza_in_limit(
        input logic signed [17:0] off,
        input logic               two_axis
    );
        logic ok;
        ok = 1'b1;
        if (two_axis && ((off > FDZA_TILT_LIMIT) || (off < -FDZA_TILT_LIMIT)))
        begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    // factory default image, calibration offsets passed in
    function automatic fdza_cfg_t fdza_defaults(
        input logic [15:0] x_cal,
        input logic [15:0] y_cal
    );
        fdza_cfg_t c;
        c.sync_message_identifier      = FDZA_DEF_SYNC_ID;
        c.communication_cycle_period   = FDZA_DEF_CYCLE;
        c.emergency_message_identifier = FDZA_DEF_EMCY_ID;
        c.heartbeat_period             = FDZA_DEF_HEARTBEAT;
        c.fault_reaction               = FDZA_DEF_FAULT;
        c.startup_behaviour            = FDZA_DEF_STARTUP;
        c.node_number                  = FDZA_DEF_NODE;
        c.bit_rate_select              = FDZA_DEF_BITRATE;
        c.bus_terminator_enable        = FDZA_DEF_TERM;
        c.profile_select               = FDZA_DEF_PROFILE;
        c.output_function_select       = FDZA_DEF_FUNCTION;
        c.moving_average_select        = FDZA_DEF_MOVAVG;
        c.output_filter_time           = FDZA_DEF_OUTFILT;
        c.fault_mask_word              = FDZA_DEF_FAULTMASK;
        c.subrange_limit               = FDZA_DEF_SUBRANGE;
        c.x_preset_value               = FDZA_DEF_PRESET;
        c.y_preset_value               = FDZA_DEF_PRESET;
        c.x_zero_offset                = x_cal;
        c.y_zero_offset                = y_cal;
        return c;
    endfunction

    // =====================================================================
    // next state
    always_comb
    begin
        logic signed [17:0] x_off;
        logic signed [17:0] y_off;
        logic               x_ok;
        logic               y_ok;
        logic               hit;
        logic [31:0]        rd;
        logic [31:0]        wd;

        // zeroing candidates from the live reading, before any request decode
        x_off = fdza_offset_for(x_raw_incl, 16'sh0000);
        y_off = fdza_offset_for(y_raw_incl, 16'sh0000);
        x_ok  = fdza_in_limit(x_off, st_q.two_axis);
        y_ok  = fdza_in_limit(y_off, st_q.two_axis);

        st_d           = st_q;
        st_d.rsp       = '0;
        st_d.nv_commit = 1'b0;
        st_d.nv_scope  = FDZA_NV_NONE;
        st_d.two_axis  = axis_sync_q[1];
        wd             = od_req.wdata;
        hit            = 1'b1;
        rd             = 32'h00000000;

        // calibration offsets are trimmed values, caught once after release
        if (!st_q.cal_loaded)
        begin
            st_d.cfg        = fdza_defaults(x_cal_offset, y_cal_offset);
            st_d.cal_loaded = 1'b1;
        end

        // offset applied to every output sample
        st_d.x_out = 16'(fdza_wrap(18'(x_raw_incl) - 18'(signed'(st_q.cfg.x_zero_offset))));
        st_d.y_out = 16'(fdza_wrap(18'(y_raw_incl) - 18'(signed'(st_q.cfg.y_zero_offset))));

        case (od_req.index)
            FDZA_IDX_SYNC_ID:   rd = st_q.cfg.sync_message_identifier;
            FDZA_IDX_CYCLE:     rd = st_q.cfg.communication_cycle_period;
            FDZA_IDX_EMCY_ID:   rd = st_q.cfg.emergency_message_identifier;
            FDZA_IDX_HEARTBEAT: rd = {16'h0000, st_q.cfg.heartbeat_period};
            FDZA_IDX_FAULT:     rd = {24'h000000, st_q.cfg.fault_reaction};
            FDZA_IDX_STARTUP:   rd = st_q.cfg.startup_behaviour;
            FDZA_IDX_NODE:      rd = {24'h000000, st_q.cfg.node_number};
            FDZA_IDX_BITRATE:   rd = {24'h000000, st_q.cfg.bit_rate_select};
            FDZA_IDX_TERM:      rd = {24'h000000, st_q.cfg.bus_terminator_enable};
            FDZA_IDX_PROFILE:   rd = {24'h000000, st_q.cfg.profile_select};
            FDZA_IDX_FUNCTION:  rd = {24'h000000, st_q.cfg.output_function_select};
            FDZA_IDX_MOVAVG:    rd = {24'h000000, st_q.cfg.moving_average_select};
            FDZA_IDX_OUTFILT:   rd = {24'h000000, st_q.cfg.output_filter_time};
            FDZA_IDX_ZERO:      rd = {24'h000000, st_q.zero_status};
            FDZA_IDX_FAULTMASK: rd = st_q.cfg.fault_mask_word;
            FDZA_IDX_SUBRANGE:  rd = {24'h000000, st_q.cfg.subrange_limit};
            FDZA_IDX_X_PRESET:  rd = {16'h0000, st_q.cfg.x_preset_value};
            FDZA_IDX_X_OFFSET:  rd = {16'h0000, st_q.cfg.x_zero_offset};
            FDZA_IDX_Y_PRESET:  rd = {16'h0000, st_q.cfg.y_preset_value};
            FDZA_IDX_Y_OFFSET:  rd = {16'h0000, st_q.cfg.y_zero_offset};
            FDZA_IDX_STORE:     rd = 32'h00000001;
            FDZA_IDX_RESTORE:   rd = 32'h00000001;
            default:            hit = 1'b0;
        endcase

        if (od_req.req && st_q.cal_loaded)
        begin
            st_d.rsp.ack   = 1'b1;
            st_d.rsp.abort = !hit;
            st_d.rsp.rdata = (hit && !od_req.write) ? rd : 32'h00000000;
            if (od_req.write && hit)
            begin
                case (od_req.index)
                    FDZA_IDX_SYNC_ID:   st_d.cfg.sync_message_identifier = wd;
                    FDZA_IDX_CYCLE:     st_d.cfg.communication_cycle_period = wd;
                    FDZA_IDX_EMCY_ID:   st_d.cfg.emergency_message_identifier = wd;
                    FDZA_IDX_HEARTBEAT: st_d.cfg.heartbeat_period = wd[15:0];
                    FDZA_IDX_FAULT:     st_d.cfg.fault_reaction = wd[7:0];
                    FDZA_IDX_STARTUP:   st_d.cfg.startup_behaviour = wd;
                    FDZA_IDX_NODE:      st_d.cfg.node_number = wd[7:0];
                    FDZA_IDX_BITRATE:   st_d.cfg.bit_rate_select = wd[7:0];
                    FDZA_IDX_TERM:      st_d.cfg.bus_terminator_enable = wd[7:0];
                    FDZA_IDX_PROFILE:   st_d.cfg.profile_select = wd[7:0];
                    FDZA_IDX_FUNCTION:  st_d.cfg.output_function_select = wd[7:0];
                    FDZA_IDX_MOVAVG:    st_d.cfg.moving_average_select = wd[7:0];
                    FDZA_IDX_OUTFILT:   st_d.cfg.output_filter_time = wd[7:0];
                    FDZA_IDX_FAULTMASK: st_d.cfg.fault_mask_word = wd;
                    FDZA_IDX_SUBRANGE:  st_d.cfg.subrange_limit = wd[7:0];
                    FDZA_IDX_X_OFFSET:  st_d.cfg.x_zero_offset = wd[15:0];
                    FDZA_IDX_Y_OFFSET:  st_d.cfg.y_zero_offset = wd[15:0];
                    FDZA_IDX_X_PRESET:
                    begin
                        // any preset whose offset passes the tilt limit works; zero is the zeroing case
                        x_off = fdza_offset_for(x_raw_incl, signed'(wd[15:0]));
                        if (fdza_in_limit(x_off, st_q.two_axis))
                        begin
                            st_d.cfg.x_preset_value = wd[15:0];
                            st_d.cfg.x_zero_offset  = 16'(x_off);
                        end
                        else
                        begin
                            st_d.rsp.abort = 1'b1;
                        end
                    end
                    FDZA_IDX_Y_PRESET:
                    begin
                        y_off = fdza_offset_for(y_raw_incl, signed'(wd[15:0]));
                        if (fdza_in_limit(y_off, st_q.two_axis))
                        begin
                            st_d.cfg.y_preset_value = wd[15:0];
                            st_d.cfg.y_zero_offset  = 16'(y_off);
                        end
                        else
                        begin
                            st_d.rsp.abort = 1'b1;
                        end
                    end
                    FDZA_IDX_ZERO:
                    begin
                        // all-axes request is all-or-nothing
                        if (wd[7:0] == FDZA_ZREQ_X && x_ok)
                        begin
                            st_d.cfg.x_zero_offset = 16'(x_off);
                            st_d.zero_status       = FDZA_ZST_OK;
                            st_d.nv_commit         = 1'b1;
                            st_d.nv_scope          = FDZA_NV_OFFSETS;
                        end
                        else if (wd[7:0] == FDZA_ZREQ_Y && y_ok)
                        begin
                            st_d.cfg.y_zero_offset = 16'(y_off);
                            st_d.zero_status       = FDZA_ZST_OK;
                            st_d.nv_commit         = 1'b1;
                            st_d.nv_scope          = FDZA_NV_OFFSETS;
                        end
                        else if (wd[7:0] == FDZA_ZREQ_ALL && x_ok && y_ok)
                        begin
                            st_d.cfg.x_zero_offset = 16'(x_off);
                            st_d.cfg.y_zero_offset = 16'(y_off);
                            st_d.zero_status       = FDZA_ZST_OK;
                            st_d.nv_commit         = 1'b1;
                            st_d.nv_scope          = FDZA_NV_OFFSETS;
                        end
                        else
                        begin
                            st_d.zero_status = FDZA_ZST_FAIL;
                        end
                    end
                    FDZA_IDX_STORE:
                    begin
                        // preset zeroing only survives power loss through here
                        if (od_req.subindex == FDZA_SUB_CMD && wd == FDZA_SIG_SAVE)
                        begin
                            st_d.nv_commit = 1'b1;
                            st_d.nv_scope  = FDZA_NV_ALL;
                        end
                        else
                        begin
                            st_d.rsp.abort = 1'b1;
                        end
                    end
                    FDZA_IDX_RESTORE:
                    begin
                        if (od_req.subindex == FDZA_SUB_CMD && wd == FDZA_SIG_LOAD)
                        begin
                            st_d.cfg         = fdza_defaults(x_cal_offset, y_cal_offset);
                            st_d.zero_status = FDZA_ZST_IDLE;
                            st_d.nv_commit   = 1'b1;
                            st_d.nv_scope    = FDZA_NV_ALL;
                        end
                        else
                        begin
                            st_d.rsp.abort = 1'b1;
                        end
                    end
                    default:
                    begin
                        st_d.rsp.abort = 1'b1;
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge core_clk or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign od_ack     = st_q.rsp.ack;
    assign od_abort   = st_q.rsp.abort;
    assign od_rdata   = st_q.rsp.rdata;
    assign x_incl_out = st_q.x_out;
    assign y_incl_out = st_q.y_out;
    assign cfg_out    = st_q.cfg;
    assign nv_commit  = st_q.nv_commit;
    assign nv_scope   = st_q.nv_scope;

endmodule // fdza_store

`default_nettype wire

// ==== hw/fdza_pkg.sv ====
// constants and carrier types for the tilt sensor configuration store
package fdza_pkg;

    // =====================================================================
    // object indices
    localparam logic [15:0] FDZA_IDX_SYNC_ID    = 16'h1005;
    localparam logic [15:0] FDZA_IDX_CYCLE      = 16'h1006;
    localparam logic [15:0] FDZA_IDX_STORE      = 16'h1010;
    localparam logic [15:0] FDZA_IDX_RESTORE    = 16'h1011;
    localparam logic [15:0] FDZA_IDX_EMCY_ID    = 16'h1014;
    localparam logic [15:0] FDZA_IDX_HEARTBEAT  = 16'h1017;
    localparam logic [15:0] FDZA_IDX_FAULT      = 16'h1029;
    localparam logic [15:0] FDZA_IDX_STARTUP    = 16'h1f80;
    localparam logic [15:0] FDZA_IDX_NODE       = 16'h3000;
    localparam logic [15:0] FDZA_IDX_BITRATE    = 16'h3001;
    localparam logic [15:0] FDZA_IDX_TERM       = 16'h3003;
    localparam logic [15:0] FDZA_IDX_PROFILE    = 16'h3004;
    localparam logic [15:0] FDZA_IDX_FUNCTION   = 16'h3007;
    localparam logic [15:0] FDZA_IDX_MOVAVG     = 16'h300d;
    localparam logic [15:0] FDZA_IDX_OUTFILT    = 16'h300e;
    localparam logic [15:0] FDZA_IDX_ZERO       = 16'h300f;
    localparam logic [15:0] FDZA_IDX_FAULTMASK  = 16'h301e;
    localparam logic [15:0] FDZA_IDX_SUBRANGE   = 16'h3032;
    localparam logic [15:0] FDZA_IDX_X_PRESET   = 16'h6012;
    localparam logic [15:0] FDZA_IDX_X_OFFSET   = 16'h6013;
    localparam logic [15:0] FDZA_IDX_Y_PRESET   = 16'h6022;
    localparam logic [15:0] FDZA_IDX_Y_OFFSET   = 16'h6023;

    // =====================================================================
    // command subindex and signatures
    localparam logic [7:0]  FDZA_SUB_CMD        = 8'h01;
    localparam logic [31:0] FDZA_SIG_SAVE       = 32'h65766173;
    localparam logic [31:0] FDZA_SIG_LOAD       = 32'h64616f6c;

    // =====================================================================
    // factory defaults
    localparam logic [31:0] FDZA_DEF_SYNC_ID    = 32'h00000080;
    localparam logic [31:0] FDZA_DEF_CYCLE      = 32'h00000000;
    localparam logic [31:0] FDZA_DEF_EMCY_ID    = 32'h00000081;
    localparam logic [15:0] FDZA_DEF_HEARTBEAT  = 16'h07d0;
    localparam logic [7:0]  FDZA_DEF_FAULT      = 8'h00;
    localparam logic [31:0] FDZA_DEF_STARTUP    = 32'h00000000;
    localparam logic [7:0]  FDZA_DEF_NODE       = 8'h01;
    localparam logic [7:0]  FDZA_DEF_BITRATE    = 8'h03;
    localparam logic [7:0]  FDZA_DEF_TERM       = 8'h00;
    localparam logic [7:0]  FDZA_DEF_PROFILE    = 8'h01;
    localparam logic [7:0]  FDZA_DEF_FUNCTION   = 8'h00;
    localparam logic [7:0]  FDZA_DEF_MOVAVG     = 8'h00;
    localparam logic [7:0]  FDZA_DEF_OUTFILT    = 8'h00;
    localparam logic [31:0] FDZA_DEF_FAULTMASK  = 32'h80001d40;
    localparam logic [7:0]  FDZA_DEF_SUBRANGE   = 8'h00;
    localparam logic [15:0] FDZA_DEF_PRESET     = 16'h0000;

    // =====================================================================
    // zero adjust: request codes, status codes, angle limits in 0.01 deg
    localparam logic [7:0]  FDZA_ZREQ_X         = 8'h01;
    localparam logic [7:0]  FDZA_ZREQ_Y         = 8'h02;
    localparam logic [7:0]  FDZA_ZREQ_ALL       = 8'h03;
    localparam logic [7:0]  FDZA_ZST_IDLE       = 8'h00;
    localparam logic [7:0]  FDZA_ZST_OK         = 8'h01;
    localparam logic [7:0]  FDZA_ZST_FAIL       = 8'h02;
    localparam logic signed [17:0] FDZA_HALF_TURN  = 18'sh04650;
    localparam logic signed [17:0] FDZA_FULL_TURN  = 18'sh08ca0;
    localparam logic signed [17:0] FDZA_TILT_LIMIT = 18'sh001f4;

    // nonvolatile commit scope
    typedef enum logic [1:0] {
        FDZA_NV_NONE    = 2'b00,
        FDZA_NV_ALL     = 2'b01,
        FDZA_NV_OFFSETS = 2'b10
    } fdza_nv_t;

    // parameter image held by the store
    typedef struct packed {
        logic [31:0] sync_message_identifier;
        logic [31:0] communication_cycle_period;
        logic [31:0] emergency_message_identifier;
        logic [15:0] heartbeat_period;
        logic [7:0]  fault_reaction;
        logic [31:0] startup_behaviour;
        logic [7:0]  node_number;
        logic [7:0]  bit_rate_select;
        logic [7:0]  bus_terminator_enable;
        logic [7:0]  profile_select;
        logic [7:0]  output_function_select;
        logic [7:0]  moving_average_select;
        logic [7:0]  output_filter_time;
        logic [31:0] fault_mask_word;
        logic [7:0]  subrange_limit;
        logic [15:0] x_preset_value;
        logic [15:0] x_zero_offset;
        logic [15:0] y_preset_value;
        logic [15:0] y_zero_offset;
    } fdza_cfg_t;

    // object access request
    typedef struct packed {
        logic        req;
        logic        write;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [31:0] wdata;
    } fdza_od_req_t;

    // object access answer
    typedef struct packed {
        logic        ack;
        logic        abort;
        logic [31:0] rdata;
    } fdza_od_rsp_t;

endpackage : fdza_pkg

// ==== tb/fdza_checker.sv ====
// port assertions for the configuration store
`timescale 1ns/1ps
`default_nettype none
module fdza_checker
    import fdza_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               rstn,
    input wire fdza_od_req_t       od_req,
    input wire logic               od_ack,
    input wire logic               od_abort,
    input wire logic signed [15:0] x_raw_incl,
    input wire logic [15:0]        x_cal_offset,
    input wire logic [15:0]        y_cal_offset,
    input wire logic signed [15:0] x_incl_out,
    input wire fdza_cfg_t          cfg_out,
    input wire logic               nv_commit,
    input wire fdza_nv_t           nv_scope
);
    // =========================================
    // write-request history
    logic rs_q;
    logic zx_q;
    logic rs_ok;
    assign rs_ok = rs_q && od_ack && !od_abort;
    always_ff @(posedge core_clk)
    begin
        rs_q <= od_req.req && od_req.write && od_req.index == FDZA_IDX_RESTORE;
        zx_q <= od_req.req && od_req.write && od_req.index == FDZA_IDX_ZERO;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_restore_beat: assert property (rs_ok |->
        cfg_out.heartbeat_period == 16'h07d0) else $error("heartbeat not restored");
    a_restore_net: assert property (rs_ok |-> cfg_out.fault_reaction == 8'h00
        && cfg_out.startup_behaviour == 32'h0) else $error("network words not restored");
    a_restore_rate: assert property (rs_ok |-> cfg_out.bit_rate_select == 8'h03
        && cfg_out.profile_select == 8'h01) else $error("rate or profile not restored");
    a_restore_filt: assert property (rs_ok |-> {cfg_out.output_function_select,
        cfg_out.moving_average_select, cfg_out.output_filter_time} == 24'h0)
        else $error("filters not restored");
    a_restore_nv: assert property (rs_ok |-> nv_commit && nv_scope == FDZA_NV_ALL)
        else $error("restore not committed");
    a_restore_offs: assert property (rs_ok |-> cfg_out.x_preset_value == 16'h0
        && cfg_out.x_zero_offset == $past(x_cal_offset)
        && cfg_out.y_zero_offset == $past(y_cal_offset)) else $error("offsets not restored");
    a_zero_commit: assert property (zx_q && od_ack && cfg_out.x_zero_offset !=
        $past(cfg_out.x_zero_offset) |-> nv_commit && nv_scope == FDZA_NV_OFFSETS)
        else $error("zero offset not committed");
    a_zero_keep: assert property (zx_q && od_ack && !nv_commit |->
        $stable(cfg_out.x_zero_offset) && $stable(cfg_out.y_zero_offset))
        else $error("refused zero moved offset");
    a_out_zero: assert property (x_raw_incl == cfg_out.x_zero_offset |=>
        x_incl_out == 16'sh0000) else $error("offset not applied");
    c_restore: cover property (rs_ok);
    c_zero: cover property (zx_q && od_ack && nv_commit);
    c_abort: cover property (od_ack && od_abort);
endmodule // fdza_checker

bind fdza_store fdza_checker chk_i (.core_clk(core_clk), .rstn(rstn), .od_req(od_req),
    .od_ack(od_ack), .od_abort(od_abort), .x_raw_incl(x_raw_incl),
    .x_cal_offset(x_cal_offset), .y_cal_offset(y_cal_offset), .x_incl_out(x_incl_out),
    .cfg_out(cfg_out), .nv_commit(nv_commit), .nv_scope(nv_scope));
`default_nettype wire

// ==== tb/fdza_master_model.sv ====
// network master model issuing object accesses
`timescale 1ns/1ps
`default_nettype none
module fdza_master_model
    import fdza_pkg::*;
(
    input  wire logic        core_clk,
    output var fdza_od_req_t od_req,
    input  wire logic        od_ack,
    input  wire logic        od_abort,
    input  wire logic [31:0] od_rdata
);
    initial od_req = '0;
    // one request pulse; the answer stands for the one cycle after the request edge
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                          output logic [33:0] ans);
        @(negedge core_clk);
        od_req = '{1'b1, wr, idx, 8'h01, wd};
        @(negedge core_clk);
        // answer is settled here; it is gone after the next rising edge
        ans = {od_ack, od_abort, od_rdata};
        od_req.req = 1'b0;
        // released data must not look valid
        od_req.wdata = ~wd;
    endtask
endmodule // fdza_master_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the configuration store
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fdza_pkg::*;
;
    logic core_clk, rstn, od_ack, od_abort, two_axis;
    logic [31:0]        od_rdata;
    logic signed [15:0] x_raw, y_raw, x_out, y_out;
    fdza_od_req_t       od_req;
    int                 fail_count, total_checks;

    fdza_store dut (.core_clk(core_clk), .rstn(rstn), .od_req(od_req), .od_ack(od_ack),
        .od_abort(od_abort), .od_rdata(od_rdata), .x_raw_incl(x_raw), .y_raw_incl(y_raw),
        .x_cal_offset(16'h0123), .y_cal_offset(16'h0045), .two_axis_pin(two_axis),
        .x_incl_out(x_out), .y_incl_out(y_out), .cfg_out(), .nv_commit(), .nv_scope());
    fdza_master_model master (.core_clk(core_clk), .od_req(od_req), .od_ack(od_ack),
        .od_abort(od_abort), .od_rdata(od_rdata));

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                       input logic ab, input logic [31:0] rd);
        logic [33:0] ans;
        master.access(wr, idx, wd, ans);
        chk(ans, {1'b1, ab, rd});
    endtask
    task automatic t_defaults;
        acc(0, FDZA_IDX_HEARTBEAT, 0, 0, 32'h7d0);
        acc(0, FDZA_IDX_FAULT, 0, 0, 32'h0);
        acc(0, FDZA_IDX_STARTUP, 0, 0, 32'h0);
        acc(0, FDZA_IDX_BITRATE, 0, 0, 32'h3);
        acc(0, FDZA_IDX_PROFILE, 0, 0, 32'h1);
        acc(0, FDZA_IDX_FUNCTION, 0, 0, 32'h0);
        acc(0, FDZA_IDX_MOVAVG, 0, 0, 32'h0);
        acc(0, FDZA_IDX_OUTFILT, 0, 0, 32'h0);
        acc(0, FDZA_IDX_X_OFFSET, 0, 0, 32'h0123);
        acc(0, FDZA_IDX_Y_PRESET, 0, 0, 32'h0);
    endtask
    task automatic t_zero_obj;
        two_axis = 1'b1;
        x_raw = 16'sd300;
        y_raw = -16'sd100;
        repeat (3) @(negedge core_clk);
        acc(1, FDZA_IDX_ZERO, 32'h3, 0, 32'h0);
        acc(0, FDZA_IDX_X_OFFSET, 0, 0, 32'h012c);
        acc(0, FDZA_IDX_Y_OFFSET, 0, 0, 32'hff9c);
        acc(0, FDZA_IDX_ZERO, 0, 0, 32'h1);
        @(negedge core_clk);
        x_raw = 16'sd350;
        repeat (2) @(negedge core_clk);
        chk({2'b00, x_out, y_out}, {2'b00, 16'h0032, 16'h0000});
        x_raw = 16'sd900;
        acc(1, FDZA_IDX_ZERO, 32'h1, 0, 32'h0);
        acc(0, FDZA_IDX_ZERO, 0, 0, 32'h2);
        acc(0, FDZA_IDX_X_OFFSET, 0, 0, 32'h012c);
        two_axis = 1'b0;
        y_raw = -16'sd17000;
        repeat (3) @(negedge core_clk);
        acc(1, FDZA_IDX_ZERO, 32'h2, 0, 32'h0);
        acc(0, FDZA_IDX_Y_OFFSET, 0, 0, 32'hbd98);
    endtask
    task automatic t_preset;
        x_raw = -16'sd200;
        acc(1, FDZA_IDX_X_PRESET, 32'h0, 0, 32'h0);
        acc(0, FDZA_IDX_X_OFFSET, 0, 0, 32'hff38);
        acc(1, FDZA_IDX_STORE, 32'h65766173, 0, 32'h0);
        acc(1, 16'h2000, 32'h1, 1, 32'h0);
        acc(1, FDZA_IDX_RESTORE, 32'h0, 1, 32'h0);
    endtask
    task automatic t_restore;
        acc(1, FDZA_IDX_BITRATE, 32'h5, 0, 32'h0);
        acc(1, FDZA_IDX_HEARTBEAT, 32'h64, 0, 32'h0);
        acc(1, FDZA_IDX_RESTORE, 32'h64616f6c, 0, 32'h0);
        acc(0, FDZA_IDX_ZERO, 0, 0, 32'h0);
        t_defaults();
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial
    begin
        {rstn, two_axis, x_raw, y_raw} = '0;
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        repeat (6) @(negedge core_clk);
        t_defaults();
        t_zero_obj();
        t_preset();
        t_restore();
        conclude();
    end
    // about 93 cycles of traffic; the limit leaves wide margin
    initial
    begin
        #100000;
        fail_count++;
        conclude();
    end
endmodule // tb_top
`default_nettype wire
